// >>> shared/sstf_consts.vh
// Purpose: constants for the serial status flag block
// Assumes: one register word per index, byte address = 4 * index
// Notes: offsets below are register indexes
`ifndef SSTF_CONSTS_VH
`define SSTF_CONSTS_VH

// ==========================================================
// register indexes
`define SSTF_IDX_STATUS 4'h0
`define SSTF_IDX_CONTROL 4'h1
`define SSTF_IDX_IRQ_STAT 4'h2
`define SSTF_IDX_IRQ_MASK 4'h3

// ==========================================================
// status field positions
`define SSTF_RXCNT_LSB 24
`define SSTF_TXCNT_LSB 16
`define SSTF_FRAME_ERROR_FLAG_BIT 12
`define SSTF_BUSY_BIT 11
`define SSTF_TUR_BIT 8
`define SSTF_SHIFTER_EMPTY_FLAG_BIT 7
`define SSTF_ROV_BIT 6
`define SSTF_RBE_BIT 5
`define SSTF_TBE_BIT 3
`define SSTF_TBF_BIT 1
`define SSTF_RBF_BIT 0

// ==========================================================
// control field positions
`define SSTF_CTL_ON_BIT 0
`define SSTF_CTL_ENH_BIT 1
`define SSTF_CTL_FRM_BIT 2
`define SSTF_CTL_WID_LSB 3

// ==========================================================
// interrupt event bits
`define SSTF_EV_ROV 0
`define SSTF_EV_TUR 1
`define SSTF_EV_FRAME_ERROR_FLAG 2
`define SSTF_EV_RXAVAIL 3
`define SSTF_EV_W 4

// ==========================================================
// widths and reset values
`define SSTF_CTL_RESET 5'h00
`define SSTF_WID_8 2'h0
`define SSTF_WID_16 2'h1
`define SSTF_WID_32 2'h2
`define SSTF_DEPTH_8 5'h10
`define SSTF_DEPTH_16 5'h08
`define SSTF_DEPTH_32 5'h04

`endif

// >>> verilog/sstf_status.v
// Purpose: status flags, fifo counts and receive buffer of a serial unit
// Assumes: shift engine supplies per-cycle events; bus inputs synchronous
// Notes: one clock domain, synchronous active-high reset
//
// Operation
// - receive fifo count in five bits
// - transmit fifo count in five bits
// - frame error flag set on framing fault while framing is enabled
// - activity flag follows engine busy
// - underrun sticks until module off then on
// - shifter empty flag mirrors shift register
// - word arriving on full buffer dropped, overflow set
// - overflow cleared only by software writing zero
// - rx empty when read pointer equals write pointer and the count is zero
// - unimplemented status bits read zero
// - fifo depth 4, 8 or 16 by width with the enhanced buffer on, one word otherwise
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`include "sstf_consts.vh"

module sstf_status #(
    parameter DW = 32,
    parameter AW = 4
) (
    clock,
    srst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    irq,
    rx_word_valid,
    rx_word,
    tx_word_take,
    tx_word,
    tx_word_avail,
    engine_busy,
    shifter_loaded,
    frame_fault,
    tx_underrun_event,
    module_on,
    enhanced_buffer_enable,
    framing_enable
);
    // clock, reset and register bus
    input wire clock;
    input wire srst;
    input wire [AW-1:0] reg_addr;
    input wire [31:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [31:0] reg_rdata;
    output reg irq;
    // shift engine side
    input wire rx_word_valid;
    input wire [DW-1:0] rx_word;
    input wire tx_word_take;
    output reg [DW-1:0] tx_word;
    output reg tx_word_avail;
    input wire engine_busy;
    input wire shifter_loaded;
    input wire frame_fault;
    input wire tx_underrun_event;
    // control bits mirrored for the engine
    output reg module_on;
    output reg enhanced_buffer_enable;
    output reg framing_enable;

    // ==========================================================
    // helpers
    // width code to fifo depth; the spare code falls back to the 32-bit depth
    function [4:0] depth_of;
        input [1:0] wid;
        begin
            case (wid)
                `SSTF_WID_8: depth_of = `SSTF_DEPTH_8;
                `SSTF_WID_16: depth_of = `SSTF_DEPTH_16;
                default: depth_of = `SSTF_DEPTH_32;
            endcase
        end
    endfunction

    // pointer step that wraps at the current capacity
    function [3:0] wrap_inc;
        input [3:0] ptr;
        input [4:0] depth;
        begin
            if ({1'b0, ptr} == depth - 5'h01) begin
                wrap_inc = 4'h0;
            end else begin
                wrap_inc = ptr + 4'h1;
            end
        end
    endfunction

    // ==========================================================
    // storage and state
    // sized for the deepest mode; shallower modes wrap early
    reg [DW-1:0] rx_mem [0:15];
    reg [DW-1:0] tx_mem [0:15];
    reg [3:0] cpu_read_pointer_r;
    reg [3:0] serial_write_pointer_r;
    reg [4:0] rx_fifo_count_r;
    reg [3:0] tx_wr_ptr_r;
    reg [3:0] tx_rd_ptr_r;
    reg [4:0] tx_fifo_count_r;
    reg [1:0] width_sel_r;
    reg frame_error_flag_r;
    reg activity_flag_r;
    reg tx_underrun_flag_r;
    reg shifter_empty_flag_r;
    reg rx_overflow_flag_r;
    reg [`SSTF_EV_W-1:0] irq_stat_r;
    reg [`SSTF_EV_W-1:0] irq_mask_r;

    wire [4:0] depth = depth_of(width_sel_r);
    // legacy mode keeps a single word buffer in each direction
    wire [4:0] cap = enhanced_buffer_enable ? depth : 5'h01;
    wire rx_full = (rx_fifo_count_r == cap);
    wire tx_full = (tx_fifo_count_r == cap);
    // pointers also meet when full, so the count settles the tie
    wire rx_fifo_empty_flag = (cpu_read_pointer_r == serial_write_pointer_r) &&
                              (rx_fifo_count_r == 5'h00);
    wire tx_empty = (tx_fifo_count_r == 5'h00);

    // ==========================================================
    // bus decode
    // one strobe qualified by one register index
    function is_hit;
        input strobe;
        input [AW-1:0] addr;
        input [AW-1:0] idx;
        begin
            is_hit = strobe && (addr == idx);
        end
    endfunction

    wire wr_status = is_hit(reg_wr, reg_addr, `SSTF_IDX_STATUS);
    wire wr_ctl = is_hit(reg_wr, reg_addr, `SSTF_IDX_CONTROL);
    wire wr_mask = is_hit(reg_wr, reg_addr, `SSTF_IDX_IRQ_MASK);
    wire rd_buf = is_hit(reg_rd, reg_addr, `SSTF_IDX_CONTROL + 4'h4);
    wire wr_buf = is_hit(reg_wr, reg_addr, `SSTF_IDX_CONTROL + 4'h4);
    wire rd_irq = is_hit(reg_rd, reg_addr, `SSTF_IDX_IRQ_STAT);

    wire rx_push = module_on && rx_word_valid && !rx_full;
    wire rx_drop = module_on && rx_word_valid && rx_full;
    wire rx_pop = rd_buf && !rx_fifo_empty_flag;
    wire tx_push = module_on && wr_buf && !tx_full;
    wire tx_pop = tx_word_take && tx_word_avail;
    wire ctl_on_nxt = reg_wdata[`SSTF_CTL_ON_BIT];
    // gated causes shared by the flags and the interrupt events
    wire ev_tur = module_on && framing_enable && tx_underrun_event;
    wire ev_frm = framing_enable && frame_fault;

    // ==========================================================
    // control register
    // control writes act at once; there is no shadow copy
    always @(posedge clock) begin
        if (srst) begin
            {width_sel_r, framing_enable, enhanced_buffer_enable, module_on} <=
                `SSTF_CTL_RESET;
            irq_mask_r <= {`SSTF_EV_W{1'b0}};
        end else begin
            if (wr_ctl) begin
                module_on <= ctl_on_nxt;
                enhanced_buffer_enable <= reg_wdata[`SSTF_CTL_ENH_BIT];
                framing_enable <= reg_wdata[`SSTF_CTL_FRM_BIT];
                width_sel_r <= reg_wdata[`SSTF_CTL_WID_LSB+1:`SSTF_CTL_WID_LSB];
            end
            if (wr_mask) begin
                irq_mask_r <= reg_wdata[`SSTF_EV_W-1:0];
            end
        end
    end

    // ==========================================================
    // receive fifo
    // flushed while the module is off, so a restart begins empty
    always @(posedge clock) begin
        if (srst || !module_on) begin
            cpu_read_pointer_r <= 4'h0;
            serial_write_pointer_r <= 4'h0;
            rx_fifo_count_r <= 5'h00;
        end else begin
            if (rx_push) begin
                rx_mem[serial_write_pointer_r] <= rx_word;
                serial_write_pointer_r <= wrap_inc(serial_write_pointer_r, cap);
            end
            if (rx_pop) begin
                cpu_read_pointer_r <= wrap_inc(cpu_read_pointer_r, cap);
            end
            rx_fifo_count_r <= rx_fifo_count_r + {4'h0, rx_push} - {4'h0, rx_pop};
        end
    end

    // ==========================================================
    // transmit fifo
    // a write to a full fifo is dropped silently
    always @(posedge clock) begin
        if (srst || !module_on) begin
            tx_wr_ptr_r <= 4'h0;
            tx_rd_ptr_r <= 4'h0;
            tx_fifo_count_r <= 5'h00;
            tx_word <= {DW{1'b0}};
            tx_word_avail <= 1'b0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wr_ptr_r] <= reg_wdata[DW-1:0];
                tx_wr_ptr_r <= wrap_inc(tx_wr_ptr_r, cap);
            end
            if (tx_pop) begin
                tx_rd_ptr_r <= wrap_inc(tx_rd_ptr_r, cap);
            end
            tx_fifo_count_r <= tx_fifo_count_r + {4'h0, tx_push} - {4'h0, tx_pop};
            // presents the head word one cycle after it lands
            tx_word <= tx_mem[tx_pop ? wrap_inc(tx_rd_ptr_r, cap) : tx_rd_ptr_r];
            tx_word_avail <= (tx_fifo_count_r - {4'h0, tx_pop}) != 5'h00;
        end
    end

    // ==========================================================
    // status flags
    // level flags follow their causes one cycle late
    always @(posedge clock) begin
        if (srst) begin
            frame_error_flag_r <= 1'b0;
        end else begin
            // meaningful only in framed operation, so gated there
            frame_error_flag_r <= ev_frm;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            activity_flag_r <= 1'b0;
        end else begin
            activity_flag_r <= engine_busy;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            shifter_empty_flag_r <= 1'b1;
        end else begin
            shifter_empty_flag_r <= !shifter_loaded;
        end
    end

    // ==========================================================
    // sticky flags
    always @(posedge clock) begin
        if (srst) begin
            tx_underrun_flag_r <= 1'b0;
        end else if (ev_tur) begin
            tx_underrun_flag_r <= 1'b1;
        end else if (wr_ctl && ctl_on_nxt && !module_on) begin
            // only the off-to-on edge of the module clears underrun
            tx_underrun_flag_r <= 1'b0;
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            rx_overflow_flag_r <= 1'b0;
        end else if (rx_drop) begin
            // hardware set beats a same-cycle software clear
            rx_overflow_flag_r <= 1'b1;
        end else if (wr_status && !reg_wdata[`SSTF_ROV_BIT]) begin
            rx_overflow_flag_r <= 1'b0;
        end
    end

    // ==========================================================
    // interrupt status, cleared by reading it
    wire [`SSTF_EV_W-1:0] ev_now;
    wire [`SSTF_EV_W-1:0] irq_stat_nxt;
    assign ev_now[`SSTF_EV_ROV] = rx_drop;
    assign ev_now[`SSTF_EV_TUR] = ev_tur;
    assign ev_now[`SSTF_EV_FRAME_ERROR_FLAG] = ev_frm;
    assign ev_now[`SSTF_EV_RXAVAIL] = rx_push;
    // a read clears what it saw; events of the same cycle survive it
    assign irq_stat_nxt = (rd_irq ? {`SSTF_EV_W{1'b0}} : irq_stat_r) | ev_now;

    always @(posedge clock) begin
        if (srst) begin
            irq_stat_r <= {`SSTF_EV_W{1'b0}};
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // irq comes from a flip-flop so it cannot glitch on decode
    always @(posedge clock) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // ==========================================================
    // read mux
    // assembled every cycle, sampled only by a status read
    reg [31:0] status_word;
    always @* begin
        status_word = 32'h00000000;
        status_word[`SSTF_RXCNT_LSB+4:`SSTF_RXCNT_LSB] = rx_fifo_count_r;
        status_word[`SSTF_TXCNT_LSB+4:`SSTF_TXCNT_LSB] = tx_fifo_count_r;
        status_word[`SSTF_FRAME_ERROR_FLAG_BIT] = frame_error_flag_r;
        status_word[`SSTF_BUSY_BIT] = activity_flag_r;
        status_word[`SSTF_TUR_BIT] = tx_underrun_flag_r;
        status_word[`SSTF_SHIFTER_EMPTY_FLAG_BIT] = shifter_empty_flag_r;
        status_word[`SSTF_ROV_BIT] = rx_overflow_flag_r;
        status_word[`SSTF_RBE_BIT] = rx_fifo_empty_flag;
        status_word[`SSTF_TBE_BIT] = tx_empty;
        status_word[`SSTF_TBF_BIT] = tx_full;
        status_word[`SSTF_RBF_BIT] = rx_full;
    end

    always @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            // read data stands one cycle only, zero otherwise
            case (reg_addr)
                `SSTF_IDX_STATUS: reg_rdata <= status_word;
                `SSTF_IDX_CONTROL: reg_rdata <= {27'h0000000, width_sel_r,
                    framing_enable, enhanced_buffer_enable, module_on};
                `SSTF_IDX_IRQ_STAT: reg_rdata <= {28'h0000000, irq_stat_r};
                `SSTF_IDX_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask_r};
                // an empty fifo returns a stale word and does not pop
                `SSTF_IDX_CONTROL + 4'h4: begin
                    reg_rdata <= 32'h00000000;
                    reg_rdata[DW-1:0] <= rx_mem[cpu_read_pointer_r];
                end
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule

// >>> bench/sstf_status_sva.sv
// Purpose: port checker for the serial status block
// Assumes: read data stands only in the cycle after the strobe
// Notes: bound into every sstf_status instance
`timescale 1ns/1ps
module sstf_status_sva #(
    parameter DW = 32,
    parameter AW = 4
) (
    input wire clock,
    input wire srst,
    input wire [AW-1:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire irq,
    input wire engine_busy,
    input wire shifter_loaded,
    input wire frame_fault,
    input wire module_on,
    input wire enhanced_buffer_enable,
    input wire framing_enable
);
    wire rd0 = reg_rd && reg_addr == 0;
    wire frm_cause = frame_fault && framing_enable;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // ==========================================================
    // status reads
    sequence st_rd;
        rd0 ##1 1'b1;
    endsequence
    reset_defaults_a: assert property (disable iff (1'b0)
        srst |=> reg_rdata == 32'h0 && !irq && !module_on) else $error("reset state");
    unused_zero_a: assert property (st_rd |-> (reg_rdata & 32'hE0E0E614) == 0)
        else $error("unused bits set");
    count_depth_a: assert property (st_rd |-> reg_rdata[28:24] <= 5'h10
        && reg_rdata[20:16] <= 5'h10) else $error("count beyond depth");
    rx_empty_a: assert property (st_rd ##0 $past(enhanced_buffer_enable)
        |-> reg_rdata[5] == (reg_rdata[28:24] == 0)) else $error("rx empty wrong");
    tx_empty_a: assert property (st_rd ##0 $past(enhanced_buffer_enable)
        |-> reg_rdata[3] == (reg_rdata[20:16] == 0)) else $error("tx empty wrong");
    // stable causes only: the flag lags its input by one cycle
    busy_follow_a: assert property ($stable(engine_busy)[*2] ##0 st_rd
        |-> reg_rdata[11] == $past(engine_busy)) else $error("activity wrong");
    shifter_mirror_a: assert property ($stable(shifter_loaded)[*2] ##0 st_rd
        |-> reg_rdata[7] == !$past(shifter_loaded)) else $error("shifter flag wrong");
    frame_follow_a: assert property ($stable(frm_cause)[*2] ##0 st_rd
        |-> reg_rdata[12] == $past(frm_cause)) else $error("frame flag wrong");
endmodule

bind sstf_status sstf_status_sva #(.DW(DW), .AW(AW)) sstf_status_sva_inst (
    .clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .engine_busy(engine_busy),
    .shifter_loaded(shifter_loaded), .frame_fault(frame_fault), .module_on(module_on),
    .enhanced_buffer_enable(enhanced_buffer_enable), .framing_enable(framing_enable));

// >>> bench/sstf_engine_model.sv
// Purpose: behavioural shift engine facing the status block
// Assumes: one received word per send pulse
// Notes: transmit words are taken whenever offered and not stalled
`timescale 1ns/1ps
module sstf_engine_model (
    input wire clock,
    input wire srst,
    input wire send,
    input wire [7:0] word,
    input wire stall,
    input wire tx_word_avail,
    input wire [7:0] tx_word,
    output logic rx_word_valid,
    output logic [7:0] rx_word,
    output wire tx_word_take,
    output logic [7:0] last_word,
    output logic [7:0] n_taken
);
    assign tx_word_take = tx_word_avail & ~stall;
    always @(posedge clock) begin
        if (srst) begin
            rx_word_valid <= 1'b0;
            rx_word <= 8'h5A;
        end else begin
            rx_word_valid <= send;
            // idle data toggles so a stale word never looks valid
            rx_word <= send ? word : ~rx_word;
        end
        if (srst) begin
            n_taken <= 8'h00;
            last_word <= 8'h00;
        end else if (tx_word_take) begin
            n_taken <= n_taken + 8'h01;
            last_word <= tx_word;
        end
    end
endmodule

// >>> bench/sstf_status_tb.sv
// Purpose: self-checking bench for the serial status block
// Assumes: index 5 is the data buffer, 8-bit words
// Notes: transmit side of the engine stalls until released
`timescale 1ns/1ps
module sstf_status_tb;
    logic clock = 0, srst = 1, reg_wr = 0, reg_rd = 0, send = 0, stall = 1;
    logic frame_fault = 0, tx_underrun_event = 0, engine_busy = 0, shifter_loaded = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, got;
    logic [7:0] word = 8'h00;
    wire [31:0] reg_rdata;
    wire [7:0] rx_word, tx_word, last_word, n_taken;
    wire irq, rx_word_valid, tx_word_take, tx_word_avail, module_on, enh, frm;
    int n_mismatch = 0, check_count = 0;
    always #12.5 clock = ~clock;
    sstf_status #(.DW(8), .AW(4)) sstf_status_inst (.clock(clock), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .rx_word_valid(rx_word_valid),
        .rx_word(rx_word), .tx_word_take(tx_word_take), .tx_word(tx_word),
        .tx_word_avail(tx_word_avail), .engine_busy(engine_busy),
        .shifter_loaded(shifter_loaded), .frame_fault(frame_fault),
        .tx_underrun_event(tx_underrun_event), .module_on(module_on),
        .enhanced_buffer_enable(enh), .framing_enable(frm));
    sstf_engine_model sstf_engine_model_inst (.clock(clock), .srst(srst), .send(send),
        .word(word), .stall(stall), .tx_word_avail(tx_word_avail), .tx_word(tx_word),
        .rx_word_valid(rx_word_valid), .rx_word(rx_word), .tx_word_take(tx_word_take),
        .last_word(last_word), .n_taken(n_taken));
    // ==========================================================
    // bus tasks
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic send_n(input int n, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            send <= 1'b1;
            word <= base + i[7:0];
        end
        @(posedge clock);
        send <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #50000;
        n_mismatch++;
        report_and_stop;
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(0, got); chk("status", 32'h000000A8, got);
        rd(4, got); chk("unmapped", 32'h0, got);
        wr(0, 32'hFFFFFFFF); rd(0, got); chk("ro status", 32'h000000A8, got);
        for (int w = 2; w >= 0; w--) begin
            wr(1, 0);
            wr(0, 0);
            wr(1, w << 3 | 3);
            send_n((16 >> w) + 1, 8'h10);
            rd(0, got); chk("rx full", (16 >> w) << 24 | 32'hC9, got);
        end
        for (int i = 0; i < 16; i++) begin
            rd(5, got); chk("rx word", 32'h10 + i, got);
        end
        rd(0, got); chk("drained", 32'h000000E8, got);
        wr(0, 0); rd(0, got); chk("ovf cleared", 32'h000000A8, got);
        rd(2, got); chk("irq stat", 32'h9, got);
        rd(2, got); chk("irq cleared", 32'h0, got);
        wr(3, 8);
        send_n(1, 8'h55); chk("irq", 32'h1, {31'h0, irq});
        rd(2, got); chk("irq stat rx", 32'h8, got);
        repeat (2) @(posedge clock); chk("irq low", 32'h0, {31'h0, irq});
        rd(5, got); chk("rx word", 32'h55, got);
        for (int i = 0; i < 17; i++) wr(5, 32'hA0 + i);
        rd(0, got); chk("tx full", 32'h001000A2, got);
        @(posedge clock) stall <= 1'b0;
        repeat (40) @(posedge clock);
        chk("taken", 32'h10, {24'h0, n_taken});
        chk("last", 32'hAF, {24'h0, last_word});
        wr(1, 7);
        frame_fault <= 1'b1;
        engine_busy <= 1'b1;
        shifter_loaded <= 1'b1;
        tx_underrun_event <= 1'b1;
        @(posedge clock) tx_underrun_event <= 1'b0;
        rd(0, got); chk("framed", 32'h00001928, got);
        chk("ctl pins", 32'h7, {29'h0, frm, enh, module_on});
        rd(3, got); chk("irq mask", 32'h8, got);
        @(posedge clock) frame_fault <= 1'b0;
        engine_busy <= 1'b0;
        shifter_loaded <= 1'b0;
        wr(1, 3); rd(0, got); chk("underrun kept", 32'h000001A8, got);
        wr(1, 0); wr(1, 7); rd(0, got); chk("underrun gone", 32'h000000A8, got);
        report_and_stop;
    end
endmodule
